// >>> hw/nvsram_defs.svh
// Constants for the partitioned nonvolatile SRAM host controller
`ifndef NVSRAM_DEFS_SVH
`define NVSRAM_DEFS_SVH

`define NVS_REG_CMD 8'h00
`define NVS_REG_ADDR 8'h04
`define NVS_REG_WDATA 8'h08
`define NVS_REG_MASK 8'h0C
`define NVS_REG_STATUS 8'h10
`define NVS_REG_RDATA 8'h14
`define NVS_REG_LOADED 8'h18

`define NVS_CMD_NONE 2'h0
`define NVS_CMD_READ 2'h1
`define NVS_CMD_WRITE 2'h2
`define NVS_CMD_PROGRAM 2'h3

`define NVS_ST_BUSY 0
`define NVS_ST_DONE 1
`define NVS_ST_PFAIL 2
`define NVS_ST_ABORT 3

`define NVS_ADDR_RESET 19'h00000
`define NVS_WDATA_RESET 8'h00
`define NVS_MASK_RESET 16'h0000

`define NVS_UNLOCK_LEN 20
`define NVS_PROG_LEN 24
`define NVS_UNLOCK_PATTERN 80'hFE7739CE7394_24A69105

`define NVS_CLK_NS 8
`define NVS_SETUP_NS 8
`define NVS_READ_PULSE_NS 70
`define NVS_WRITE_PULSE_NS 70
`define NVS_RECOVERY_NS 10
`define NVS_NS_TO_CYC(ns) (((ns) + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_SETUP_CYC `NVS_NS_TO_CYC(`NVS_SETUP_NS)
`define NVS_READ_PULSE_CYC `NVS_NS_TO_CYC(`NVS_READ_PULSE_NS)
`define NVS_WRITE_PULSE_CYC `NVS_NS_TO_CYC(`NVS_WRITE_PULSE_NS)
`define NVS_RECOVERY_CYC `NVS_NS_TO_CYC(`NVS_RECOVERY_NS)

`endif

// >>> hw/nvsram_pkg.sv
// Types shared by the host controller and its pin cycle engine
`default_nettype none
package nvsram_pkg;
    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_PULSE = 4'b0100,
        CY_RECOV = 4'b1000
    } cyc_state_e;

    typedef enum logic [2:0] {
        CT_IDLE = 3'b001,
        CT_SINGLE = 3'b010,
        CT_PROG = 3'b100
    } ctl_state_e;
endpackage
`default_nettype wire

// >>> hw/nvsram_cycle.sv
// Pin cycle engine: one timed asynchronous read or write on the SRAM pins
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_defs.svh"
module nvsram_cycle import nvsram_pkg::*; #(
    parameter int SETUP_CYC = `NVS_SETUP_CYC,
    parameter int READ_PULSE_CYC = `NVS_READ_PULSE_CYC,
    parameter int WRITE_PULSE_CYC = `NVS_WRITE_PULSE_CYC,
    parameter int RECOVERY_CYC = `NVS_RECOVERY_CYC,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request from the controller
    input wire logic start,
    input wire logic start_write,
    input wire logic [18:0] start_addr,
    input wire logic [7:0] start_wdata,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    // SRAM pins
    output logic [18:0] address_bus,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic [7:0] data_bus_o,
    input wire logic [7:0] data_bus_i,
    output logic data_bus_oe_n
);
    cyc_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic write_q;

    wire cnt_end = (cnt_q == '0);
    wire [CNT_W-1:0] setup_cnt = CNT_W'(SETUP_CYC - 1);
    wire [CNT_W-1:0] pulse_cnt = write_q ? CNT_W'(WRITE_PULSE_CYC - 1)
                                         : CNT_W'(READ_PULSE_CYC - 1);
    wire [CNT_W-1:0] recov_cnt = CNT_W'(RECOVERY_CYC - 1);

    assign busy = (state_q != CY_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= CY_IDLE;
            cnt_q <= '0;
            write_q <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            address_bus <= 19'h00000;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            data_bus_o <= 8'h00;
            data_bus_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_q)
                CY_IDLE: begin
                    if (start) begin
                        // Address and select settle before any strobe
                        address_bus <= start_addr;
                        chip_select_n <= 1'b0;
                        write_q <= start_write;
                        data_bus_o <= start_wdata;
                        data_bus_oe_n <= !start_write;
                        cnt_q <= setup_cnt;
                        state_q <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (cnt_end) begin
                        // Write strobe falls after select: start of write
                        write_strobe_n <= !write_q;
                        output_drive_n <= write_q;
                        cnt_q <= pulse_cnt;
                        state_q <= CY_PULSE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                CY_PULSE: begin
                    if (cnt_end) begin
                        if (!write_q) begin
                            rdata <= data_bus_i;
                        end
                        // Select and strobe rise together; address held till now
                        chip_select_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        output_drive_n <= 1'b1;
                        cnt_q <= recov_cnt;
                        state_q <= CY_RECOV;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                CY_RECOV: begin
                    // Data held one cycle past strobe rise, then released
                    data_bus_oe_n <= 1'b1;
                    if (cnt_end) begin
                        done <= 1'b1;
                        state_q <= CY_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= CY_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hw/nvsram_host.sv
// AHB-Lite host controller for the partitioned nonvolatile SRAM
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_defs.svh"
module nvsram_host import nvsram_pkg::*; #(
    parameter int SETUP_CYC = `NVS_SETUP_CYC,
    parameter int READ_PULSE_CYC = `NVS_READ_PULSE_CYC,
    parameter int WRITE_PULSE_CYC = `NVS_WRITE_PULSE_CYC,
    parameter int RECOVERY_CYC = `NVS_RECOVERY_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // SRAM pins
    output logic [18:0] address_bus,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    output logic [7:0] data_bus_o,
    input wire logic [7:0] data_bus_i,
    output logic data_bus_oe_n,
    // Supply status from the memory module
    input wire logic power_fail_warning
);
    // Unlock nibble for programming read idx (0 based), A18..A15 order
    function automatic logic [3:0] unlock_nibble(input logic [4:0] idx);
        logic [79:0] p;
        logic [6:0] sh;
        sh = 7'h4C - {idx, 2'b00};
        p = `NVS_UNLOCK_PATTERN >> sh;
        return p[3:0];
    endfunction

    // Mask nibble carried by load read j: bit i goes out on line 15+i
    function automatic logic [3:0] mask_nibble(input logic [15:0] mask, input logic [1:0] j);
        logic [15:0] m;
        m = mask >> {j, 2'b00};
        return m[3:0];
    endfunction

    // Register state
    logic [18:0] addr_q;
    logic [7:0] wdata_q;
    logic [15:0] mask_q;
    logic [15:0] loaded_q;
    logic [7:0] rdata_q;
    logic [1:0] last_cmd_q;
    logic done_q;
    logic abort_q;

    // Bus state
    logic wr_pend_q;
    logic [7:0] wr_off_q;

    // Sequencer state
    ctl_state_e state_q;
    logic [4:0] idx_q;
    logic issued_q;
    logic op_write_q;
    logic start_q;
    logic [18:0] start_addr_q;

    // Engine answers
    logic eng_busy;
    logic eng_done;
    logic [7:0] eng_rdata;

    // Address phase decode
    wire addr_ok = hsel && htrans[1] && hready;
    wire rd_take = addr_ok && !hwrite;
    wire [7:0] rd_off = haddr[7:0];

    wire [31:0] status_word = {28'h0000000, abort_q, power_fail_warning, done_q,
                               (state_q != CT_IDLE)};
    wire [31:0] rd_value =
        (rd_off == `NVS_REG_CMD) ? {30'h00000000, last_cmd_q} :
        (rd_off == `NVS_REG_ADDR) ? {13'h0000, addr_q} :
        (rd_off == `NVS_REG_WDATA) ? {24'h000000, wdata_q} :
        (rd_off == `NVS_REG_MASK) ? {16'h0000, mask_q} :
        (rd_off == `NVS_REG_STATUS) ? status_word :
        (rd_off == `NVS_REG_RDATA) ? {24'h000000, rdata_q} :
        (rd_off == `NVS_REG_LOADED) ? {16'h0000, loaded_q} :
        32'h00000000;

    // Data phase write decode
    wire wr_cmd = wr_pend_q && (wr_off_q == `NVS_REG_CMD);
    wire wr_addr = wr_pend_q && (wr_off_q == `NVS_REG_ADDR);
    wire wr_wdata = wr_pend_q && (wr_off_q == `NVS_REG_WDATA);
    wire wr_mask = wr_pend_q && (wr_off_q == `NVS_REG_MASK);
    wire wr_status = wr_pend_q && (wr_off_q == `NVS_REG_STATUS);
    wire [1:0] cmd_code = hwdata[1:0];

    // Command acceptance; busy commands are dropped, fault commands abort
    wire idle = (state_q == CT_IDLE);
    wire cmd_valid = wr_cmd && idle && (cmd_code != `NVS_CMD_NONE);
    wire cmd_go = cmd_valid && !power_fail_warning;
    wire cmd_pf = cmd_valid && power_fail_warning;

    // Cycle issue towards the engine
    wire issue = !idle && !issued_q && !eng_busy;
    wire abort_now = issue && power_fail_warning;
    wire start_d = issue && !power_fail_warning;
    wire last_prog = (idx_q == 5'(`NVS_PROG_LEN - 1));
    wire in_unlock = (idx_q < 5'(`NVS_UNLOCK_LEN));
    wire [1:0] load_j = 2'(idx_q - 5'(`NVS_UNLOCK_LEN));
    // Unlock reads, then mask reads; low lines carry the address register
    wire [3:0] prog_nib = in_unlock ? unlock_nibble(idx_q)
                                    : mask_nibble(mask_q, load_j);
    wire [18:0] next_addr = (state_q == CT_PROG) ? {prog_nib, addr_q[14:0]} : addr_q;

    // Sticky flags: a set in the same cycle as a clear wins
    wire done_set = eng_done && ((state_q == CT_SINGLE) || last_prog);
    wire abort_set = abort_now || cmd_pf;
    wire done_clr = wr_status && hwdata[`NVS_ST_DONE];
    wire abort_clr = wr_status && hwdata[`NVS_ST_ABORT];

    // AHB slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data stands for the one data phase cycle only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else begin
            hrdata <= rd_take ? rd_value : 32'h00000000;
        end
    end

    // Write address phase kept for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_off_q <= haddr[7:0];
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= `NVS_ADDR_RESET;
            wdata_q <= `NVS_WDATA_RESET;
            mask_q <= `NVS_MASK_RESET;
            last_cmd_q <= `NVS_CMD_NONE;
        end else begin
            if (wr_addr) begin
                addr_q <= hwdata[18:0];
            end
            if (wr_wdata) begin
                wdata_q <= hwdata[7:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata[15:0];
            end
            if (wr_cmd) begin
                last_cmd_q <= cmd_code;
            end
        end
    end

    // Done flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_set || (done_q && !done_clr);
        end
    end

    // Abort flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= abort_set || (abort_q && !abort_clr);
        end
    end

    // Data of single reads; data returned by programming reads is discarded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 8'h00;
        end else begin
            if (eng_done && (state_q == CT_SINGLE) && !op_write_q) begin
                rdata_q <= eng_rdata;
            end
        end
    end

    // Host copy of the mask last loaded into the device
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loaded_q <= `NVS_MASK_RESET;
        end else begin
            if (eng_done && (state_q == CT_PROG) && last_prog) begin
                loaded_q <= mask_q;
            end
        end
    end

    // Command sequencer; a program run issues only reads, never a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= CT_IDLE;
            idx_q <= 5'h00;
            issued_q <= 1'b0;
            op_write_q <= 1'b0;
        end else begin
            case (state_q)
                CT_IDLE: begin
                    issued_q <= 1'b0;
                    idx_q <= 5'h00;
                    if (cmd_go) begin
                        op_write_q <= (cmd_code == `NVS_CMD_WRITE);
                        state_q <= (cmd_code == `NVS_CMD_PROGRAM) ? CT_PROG : CT_SINGLE;
                    end
                end
                CT_SINGLE: begin
                    if (abort_now) begin
                        state_q <= CT_IDLE;
                    end else if (start_d) begin
                        issued_q <= 1'b1;
                    end else if (eng_done) begin
                        issued_q <= 1'b0;
                        state_q <= CT_IDLE;
                    end
                end
                CT_PROG: begin
                    if (abort_now) begin
                        state_q <= CT_IDLE;
                    end else if (start_d) begin
                        issued_q <= 1'b1;
                    end else if (eng_done) begin
                        issued_q <= 1'b0;
                        idx_q <= idx_q + 5'h01;
                        if (last_prog) begin
                            state_q <= CT_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= CT_IDLE;
                end
            endcase
        end
    end

    // Launch strobe towards the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
        end
    end

    // Launch address, aligned with the strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_addr_q <= 19'h00000;
        end else begin
            start_addr_q <= next_addr;
        end
    end

    wire start_is_write = op_write_q && (state_q == CT_SINGLE);

    nvsram_cycle #(
        .SETUP_CYC(SETUP_CYC),
        .READ_PULSE_CYC(READ_PULSE_CYC),
        .WRITE_PULSE_CYC(WRITE_PULSE_CYC),
        .RECOVERY_CYC(RECOVERY_CYC),
        .CNT_W(8)
    ) u_cycle (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(start_q),
        .start_write(start_is_write),
        .start_addr(start_addr_q),
        .start_wdata(wdata_q),
        .busy(eng_busy),
        .done(eng_done),
        .rdata(eng_rdata),
        .address_bus(address_bus),
        .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n),
        .output_drive_n(output_drive_n),
        .data_bus_o(data_bus_o),
        .data_bus_i(data_bus_i),
        .data_bus_oe_n(data_bus_oe_n)
    );
endmodule
`default_nettype wire

// >>> testbench/nvsram_host_props.sv
// Pin and bus checks for the nonvolatile SRAM host controller
`timescale 1ns/100ps
`default_nettype none
module nvsram_host_props #(
    parameter int RECOVERY_CYC = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // SRAM pins
    input wire logic [18:0] address_bus,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [7:0] data_bus_o,
    input wire logic data_bus_oe_n,
    // Supply status
    input wire logic power_fail_warning
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] since_wr_q;
    logic [3:0] pf_cnt_q;
    // Cycles since the strobe was last low, and cycles of steady supply fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) since_wr_q <= 8'hFF;
        else if (!write_strobe_n) since_wr_q <= 8'h00;
        else if (since_wr_q != 8'hFF) since_wr_q <= since_wr_q + 8'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pf_cnt_q <= 4'h0;
        else if (!power_fail_warning) pf_cnt_q <= 4'h0;
        else if (pf_cnt_q != 4'hF) pf_cnt_q <= pf_cnt_q + 4'h1;
    end
    chk_oe_in_write: assert property (!write_strobe_n |-> output_drive_n)
        else $error("output drive low during write");
    chk_bus_no_fight: assert property (!data_bus_oe_n |-> output_drive_n)
        else $error("host drives data while memory outputs enabled");
    chk_idle_quiet: assert property (chip_select_n
        |-> write_strobe_n && output_drive_n)
        else $error("strobe active without select");
    chk_addr_hold: assert property (!chip_select_n && $past(!chip_select_n)
        |-> $stable(address_bus))
        else $error("address moved inside a cycle");
    chk_write_recov: assert property ($fell(chip_select_n)
        |-> int'(since_wr_q) >= RECOVERY_CYC)
        else $error("new cycle before write recovery");
    chk_data_lead: assert property ($fell(write_strobe_n)
        |-> !data_bus_oe_n && $past(!data_bus_oe_n))
        else $error("write strobe before data driven");
    chk_wdata_hold: assert property (!write_strobe_n && $past(!write_strobe_n)
        |-> $stable(data_bus_o))
        else $error("write data moved under strobe");
    chk_okay_resp: assert property (hresp == 1'b0)
        else $error("non OKAY response");
    chk_unmapped_zero: assert property (hsel && htrans[1] && !hwrite && hready
        && haddr[7:0] == 8'h1C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_pf_no_cycle: assert property ($fell(chip_select_n) |-> pf_cnt_q < 4'h8)
        else $error("cycle issued during supply fault");
    cover property ($fell(write_strobe_n));
    cover property ($fell(output_drive_n));
    cover property (power_fail_warning && hsel && htrans[1] && hwrite);
endmodule
bind nvsram_host nvsram_host_props #(.RECOVERY_CYC(RECOVERY_CYC)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
    .address_bus(address_bus), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
    .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n),
    .power_fail_warning(power_fail_warning));
`default_nettype wire

// >>> testbench/nvsram_dev_model.sv
// Behavioural model of the partitioned nonvolatile SRAM
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_defs.svh"
module nvsram_dev_model (
    // Pins driven by the host
    input wire logic [18:0] address_bus,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [7:0] data_bus_o,
    input wire logic data_bus_oe_n,
    // Supply status
    input wire logic power_fail_warning,
    // Data seen by the host
    output logic [7:0] data_bus_i
);
    localparam logic [79:0] PAT = `NVS_UNLOCK_PATTERN;
    logic [7:0] mem [logic [18:0]];
    logic [15:0] mask_q = 16'h0000;
    logic [15:0] load_q = 16'h0000;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rd_val = 8'h5A;
    int cnt_q = 0;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic armed_q = 1'b0;
    logic drv;
    assign drv = !chip_select_n && !output_drive_n && write_strobe_n
        && !power_fail_warning;
    always @(address_bus or chip_select_n or output_drive_n) begin
        rd_val = mem.exists(address_bus) ? mem[address_bus] : 8'h5A;
    end
    // A released bus shows the inverse of its last level
    always @(data_bus_oe_n or data_bus_o or drv or rd_val) begin
        if (!data_bus_oe_n) last_q = data_bus_o;
        else if (drv) last_q = rd_val;
    end
    assign data_bus_i = !data_bus_oe_n ? data_bus_o : (drv ? rd_val : ~last_q);
    always @(power_fail_warning or address_bus) begin
        if (!power_fail_warning) armed_q = 1'b1;
    end
    task automatic step(input logic [3:0] n);
        if (cnt_q < `NVS_UNLOCK_LEN) begin
            if (n == PAT[4*(19-cnt_q) +: 4]) cnt_q++;
            else cnt_q = (n == PAT[79:76]) ? 1 : 0;
        end else begin
            load_q[4*(cnt_q-20) +: 4] = n;
            cnt_q++;
            if (cnt_q == `NVS_PROG_LEN) begin
                mask_q = load_q;
                cnt_q = 0;
            end
        end
    endtask
    always @(negedge output_drive_n) begin
        if (!chip_select_n && write_strobe_n && !power_fail_warning) rd_q = 1'b1;
    end
    always @(posedge chip_select_n) begin
        if (rd_q) begin
            rd_q = 1'b0;
            step(address_bus[18:15]);
        end
    end
    always @(negedge chip_select_n or negedge write_strobe_n) begin
        if (!chip_select_n && !write_strobe_n && !power_fail_warning) wr_q = 1'b1;
    end
    always @(posedge chip_select_n or posedge write_strobe_n) begin
        if (wr_q) begin
            wr_q = 1'b0;
            cnt_q = 0;
            if (!power_fail_warning && !mask_q[address_bus[18:15]]) begin
                mem[address_bus] = data_bus_o;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Register level testbench for the nonvolatile SRAM host controller
`timescale 1ns/100ps
`default_nettype none
`include "nvsram_defs.svh"
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic power_fail_warning = 1'b0;
    logic hreadyout, hresp, chip_select_n, write_strobe_n, output_drive_n, data_bus_oe_n;
    logic [31:0] hrdata;
    logic [18:0] address_bus;
    logic [7:0] data_bus_o, data_bus_i;
    logic [31:0] rd, st;
    logic [15:0] masks [2] = '{16'h0020, 16'h8421};
    int fail_count = 0;
    int checked = 0;
    always #4 hclk = ~hclk;
    nvsram_host #(.SETUP_CYC(1), .READ_PULSE_CYC(2), .WRITE_PULSE_CYC(2), .RECOVERY_CYC(2)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .address_bus(address_bus),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_drive_n(output_drive_n), .data_bus_o(data_bus_o), .data_bus_i(data_bus_i),
        .data_bus_oe_n(data_bus_oe_n), .power_fail_warning(power_fail_warning));
    nvsram_dev_model u_dev (
        .address_bus(address_bus), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
        .data_bus_o(data_bus_o), .data_bus_oe_n(data_bus_oe_n),
        .power_fail_warning(power_fail_warning), .data_bus_i(data_bus_i));
    task close_out;
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task hang(input int n);
        if (n > 600) begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            close_out;
        end
    endtask
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            hang(n * 20);
            @(posedge hclk);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask
    // Issue a command and wait for done or abort, then clear both
    task run(input logic [1:0] cmd);
        int n;
        ahb(1'b1, `NVS_REG_CMD, {30'h0, cmd});
        n = 0;
        rd = 32'h0;
        while (!(rd[`NVS_ST_DONE] === 1'b1 || rd[`NVS_ST_ABORT] === 1'b1)) begin
            n++;
            hang(n);
            ahb(1'b0, `NVS_REG_STATUS, 32'h0);
        end
        st = rd;
        ahb(1'b1, `NVS_REG_STATUS, 32'hA);
    endtask
    task poke(input logic [18:0] a, input logic [7:0] d);
        ahb(1'b1, `NVS_REG_ADDR, {13'h0, a});
        ahb(1'b1, `NVS_REG_WDATA, {24'h0, d});
        run(`NVS_CMD_WRITE);
    endtask
    task peek(input logic [18:0] a);
        ahb(1'b1, `NVS_REG_ADDR, {13'h0, a});
        run(`NVS_CMD_READ);
        ahb(1'b0, `NVS_REG_RDATA, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 1; i < 8; i++) begin
            ahb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        ahb(1'b1, `NVS_REG_ADDR, 32'hFFFF_FFFF);
        ahb(1'b0, `NVS_REG_ADDR, 32'h0);
        chk(rd, 32'h0007_FFFF);
        for (int p = 0; p < 6; p++) poke({4'(p), 15'h0123}, 8'(8'h10 + p));
        foreach (masks[m]) begin
            ahb(1'b1, `NVS_REG_MASK, {16'h0, masks[m]});
            run(`NVS_CMD_PROGRAM);
            ahb(1'b0, `NVS_REG_LOADED, 32'h0);
            chk(rd, {16'h0, masks[m]});
            chk({16'h0, u_dev.mask_q}, {16'h0, masks[m]});
        end
        for (int p = 0; p < 6; p++) begin
            poke({4'(p), 15'h0123}, 8'hC0);
            peek({4'(p), 15'h0123});
            chk(rd, masks[1][p] ? 32'(8'h10 + p) : 32'h0000_00C0);
        end
        power_fail_warning <= 1'b1;
        repeat (10) @(posedge hclk);
        poke(19'h20123, 8'h77);
        chk(st & 32'hF, 32'hC);
        power_fail_warning <= 1'b0;
        repeat (4) @(posedge hclk);
        ahb(1'b0, `NVS_REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        peek(19'h20123);
        chk(rd, 32'h0000_00C0);
        close_out;
    end
endmodule
`default_nettype wire
